/* core/rtp_timer.v */
/*
 * 16-bit reload timer with prescaler, dual complementary pwm output with
 * deadband, and input capture; apb slave register file and interrupts.
 * assumes one pclk domain; timer_in is an asynchronous pin.
 */
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`include "rtp_consts.vh"
module rtp_timer (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    timer_in,
    pwm_out,
    pwm_out_n,
    pwm_oe_n,
    reload_pulse,
    capture_pulse,
    irq
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [7:0]  paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output reg         pready;
    output reg         pslverr;
    input  wire        timer_in;
    output reg         pwm_out;
    output reg         pwm_out_n;
    output reg         pwm_oe_n;
    output reg         reload_pulse;
    output reg         capture_pulse;
    output reg         irq;

    reg  [5:0]  ctl_reg;
    reg  [15:0] count_reg;
    reg  [15:0] reload_reg;
    reg  [15:0] pwm_reg;
    reg  [7:0]  db_reg;
    reg         cap_flag_reg;
    reg  [1:0]  int_stat_reg;
    reg  [1:0]  int_mask_reg;
    reg  [6:0]  pre_reg;
    reg         raw_reg;
    reg         en_d_reg;
    reg  [2:0]  sync_reg;
    reg         in_level_reg;
    reg  [1:0]  int_stat_next;

    wire        enable;
    wire        cap_mode;
    wire        polarity;
    wire [2:0]  pre_sel;
    wire [6:0]  pre_limit;
    wire        tick;
    wire        at_reload;
    wire        at_match;
    wire        reload_ev;
    wire        in_edge;
    wire        capture_ev;
    wire        wr_en;
    wire        setup;
    wire        mapped;
    wire        db_a;
    wire        db_b;

    assign enable    = ctl_reg[`RTP_CTL_EN_BIT];
    assign cap_mode  = ctl_reg[`RTP_CTL_MODE_BIT];
    assign polarity  = ctl_reg[`RTP_CTL_POL_BIT];
    assign pre_sel   = ctl_reg[`RTP_CTL_PRE_MSB:`RTP_CTL_PRE_LSB];
    assign pre_limit = (7'h01 << pre_sel) - 7'h01;
    assign tick      = enable && (pre_reg == pre_limit);
    assign at_reload = (count_reg == reload_reg);
    assign at_match  = (count_reg == pwm_reg);
    assign reload_ev = tick && at_reload;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pready && pwrite;
    assign mapped = (paddr == `RTP_OFF_CTL) || (paddr == `RTP_OFF_COUNT) ||
                    (paddr == `RTP_OFF_RELOAD) || (paddr == `RTP_OFF_PWM) ||
                    (paddr == `RTP_OFF_CTL2) ||
                    (paddr == `RTP_OFF_INT_STAT) ||
                    (paddr == `RTP_OFF_INT_MASK);

    // input pin: three flops, level changes once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg     <= 3'h0;
            in_level_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], timer_in};
            if (sync_reg[1] == sync_reg[2]) begin
                in_level_reg <= sync_reg[2];
            end
        end
    end

    // polarity one captures on rising edge, zero on falling edge
    assign in_edge = (sync_reg[1] == sync_reg[2]) &&
                     (sync_reg[2] != in_level_reg) &&
                     (sync_reg[2] == polarity);
    assign capture_ev = enable && cap_mode && in_edge;

    // prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 7'h00;
        end else if (!enable || tick) begin
            pre_reg <= 7'h00;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    // control and configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg      <= `RTP_RST_CTL;
            reload_reg   <= `RTP_RST_RELOAD;
            db_reg       <= `RTP_RST_DB;
            int_mask_reg <= `RTP_RST_INT;
        end else if (wr_en) begin
            case (paddr)
                `RTP_OFF_CTL: begin
                    ctl_reg <= pwdata[5:0];
                end
                `RTP_OFF_RELOAD: begin
                    reload_reg <= pwdata[15:0];
                end
                `RTP_OFF_CTL2: begin
                    db_reg <= pwdata[`RTP_CTL2_DB_MSB:`RTP_CTL2_DB_LSB];
                end
                `RTP_OFF_INT_MASK: begin
                    int_mask_reg <= pwdata[1:0];
                end
                default: begin
                    ctl_reg <= ctl_reg;
                end
            endcase
        end
    end

    // counter: software load wins over the running count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `RTP_RST_COUNT;
        end else if (wr_en && (paddr == `RTP_OFF_COUNT)) begin
            count_reg <= pwdata[15:0];
        end else if (tick) begin
            if (at_reload) begin
                count_reg <= `RTP_COUNT_RESTART;
            end else begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end

    // pwm match value, overwritten by a capture; capture wins over a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_reg <= `RTP_RST_PWM;
        end else if (capture_ev) begin
            pwm_reg <= count_reg;
        end else if (wr_en && (paddr == `RTP_OFF_PWM)) begin
            pwm_reg <= pwdata[15:0];
        end
    end

    // input capture flag: set on capture, cleared on reload in capture mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_flag_reg <= 1'b0;
        end else if (capture_ev) begin
            cap_flag_reg <= 1'b1;
        end else if (reload_ev && cap_mode) begin
            cap_flag_reg <= 1'b0;
        end
    end

    // primary pwm level before deadband
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_reg  <= 1'b0;
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= enable;
            if (enable && !en_d_reg) begin
                raw_reg <= polarity;
            end else if (tick && !cap_mode) begin
                if (at_reload) begin
                    raw_reg <= polarity;
                end else if (at_match) begin
                    raw_reg <= ~polarity;
                end
            end
        end
    end

    rtp_deadband u_db_a (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (raw_reg && !cap_mode),
        .delay_cfg (db_reg),
        .level_out (db_a)
    );

    rtp_deadband u_db_b (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (!raw_reg && !cap_mode),
        .delay_cfg (db_reg),
        .level_out (db_b)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out   <= 1'b0;
            pwm_out_n <= 1'b0;
            pwm_oe_n  <= 1'b1;
        end else begin
            // outputs drop together with capture mode, not after the chain
            pwm_out   <= db_a && !cap_mode;
            pwm_out_n <= db_b && !cap_mode;
            pwm_oe_n  <= cap_mode;
        end
    end

    // sticky status, hardware set wins over write-one-to-clear
    always @* begin
        int_stat_next = int_stat_reg;
        if (wr_en && (paddr == `RTP_OFF_INT_STAT)) begin
            int_stat_next = int_stat_reg & ~pwdata[1:0];
        end
        if (reload_ev) begin
            int_stat_next[`RTP_INT_RELOAD_BIT] = 1'b1;
        end
        if (capture_ev) begin
            int_stat_next[`RTP_INT_CAP_BIT] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg  <= `RTP_RST_INT;
            irq           <= 1'b0;
            reload_pulse  <= 1'b0;
            capture_pulse <= 1'b0;
        end else begin
            int_stat_reg  <= int_stat_next;
            irq           <= |(int_stat_next & int_mask_reg);
            reload_pulse  <= reload_ev;
            capture_pulse <= capture_ev;
        end
    end

    // apb: read data and answer prepared in setup, shown in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= 32'h00000000;
            if (setup && !pwrite) begin
                case (paddr)
                    `RTP_OFF_CTL: begin
                        prdata <= {26'h0000000, ctl_reg};
                    end
                    `RTP_OFF_COUNT: begin
                        prdata <= {16'h0000, count_reg};
                    end
                    `RTP_OFF_RELOAD: begin
                        prdata <= {16'h0000, reload_reg};
                    end
                    `RTP_OFF_PWM: begin
                        prdata <= {16'h0000, pwm_reg};
                    end
                    `RTP_OFF_CTL2: begin
                        prdata <= {23'h000000, cap_flag_reg, db_reg};
                    end
                    `RTP_OFF_INT_STAT: begin
                        prdata <= {30'h00000000, int_stat_reg};
                    end
                    `RTP_OFF_INT_MASK: begin
                        prdata <= {30'h00000000, int_mask_reg};
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end
endmodule // rtp_timer

/* pkg/rtp_consts.vh */
/*
 * register offsets, field positions and reset values of the reload timer.
 * assumes inclusion by bare name from the core files.
 */
`ifndef RTP_CONSTS_VH
`define RTP_CONSTS_VH

`define RTP_OFF_CTL        8'h00
`define RTP_OFF_COUNT      8'h04
`define RTP_OFF_RELOAD     8'h08
`define RTP_OFF_PWM        8'h0c
`define RTP_OFF_CTL2       8'h10
`define RTP_OFF_INT_STAT   8'h14
`define RTP_OFF_INT_MASK   8'h18

`define RTP_CTL_EN_BIT     0
`define RTP_CTL_MODE_BIT   1
`define RTP_CTL_PRE_LSB    2
`define RTP_CTL_PRE_MSB    4
`define RTP_CTL_POL_BIT    5

`define RTP_CTL2_DB_LSB    0
`define RTP_CTL2_DB_MSB    7
`define RTP_CTL2_CAP_BIT   8

`define RTP_INT_RELOAD_BIT 0
`define RTP_INT_CAP_BIT    1

`define RTP_RST_CTL        6'h00
`define RTP_RST_COUNT      16'h0001
`define RTP_RST_RELOAD     16'hffff
`define RTP_RST_PWM        16'h0000
`define RTP_RST_DB         8'h00
`define RTP_RST_INT        2'h0
`define RTP_COUNT_RESTART  16'h0001
`define RTP_DB_MAX         8'h80

`endif

/* core/rtp_deadband.v */
/*
 * delays the low-to-high edge of one output by a programmed number of
 * clock cycles, at most RTP_DB_MAX (128); high-to-low edges pass after one register stage.
 * assumes delay_cfg is static while the output is in use.
 */
`timescale 1ns/100ps
`include "rtp_consts.vh"
module rtp_deadband (
    pclk,
    presetn,
    level_in,
    delay_cfg,
    level_out
);
    input  wire       pclk;
    input  wire       presetn;
    input  wire       level_in;
    input  wire [7:0] delay_cfg;
    output reg        level_out;

    reg [7:0] wait_reg;
    wire [7:0] limit;

    assign limit = (delay_cfg > `RTP_DB_MAX) ? `RTP_DB_MAX : delay_cfg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg  <= 8'h00;
            level_out <= 1'b0;
        end else if (!level_in) begin
            wait_reg  <= 8'h00;
            level_out <= 1'b0;
        end else if (wait_reg >= limit) begin
            level_out <= 1'b1;
        end else begin
            wait_reg  <= wait_reg + 8'h01;
        end
    end
endmodule // rtp_deadband

/* test/rtp_timer_asserts.sv */
/* port checker for rtp_timer.
   assumes one pclk domain; bound to every rtp_timer instance. */
`timescale 1ns/100ps
module rtp_timer_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        timer_in,
    input wire        pwm_out,
    input wire        pwm_out_n,
    input wire        pwm_oe_n,
    input wire        reload_pulse,
    input wire        capture_pulse,
    input wire        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (psel && !penable && paddr > 8'h18
        |=> pslverr) else $error("no pslverr on unmapped address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_reload_pulse_single: assert property (
        reload_pulse |=> !reload_pulse)
        else $error("reload pulse too long");
    a_capture_pulse_single: assert property (
        capture_pulse |=> !capture_pulse)
        else $error("capture pulse too long");
    a_comp_no_overlap: assert property (!(pwm_out && pwm_out_n))
        else $error("both pwm outputs high");
    a_cap_outputs_low: assert property (pwm_oe_n |-> !pwm_out && !pwm_out_n)
        else $error("pwm outputs active in capture mode");
endmodule // rtp_timer_asserts

bind rtp_timer rtp_timer_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
    .pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .pwm_oe_n(pwm_oe_n),
    .reload_pulse(reload_pulse), .capture_pulse(capture_pulse), .irq(irq)
);

/* test/rtp_pin_model.sv */
/* external driver of the timer input pin.
   assumes one pclk domain; follows level_req at a limited rate. */
`timescale 1ns/100ps
module rtp_pin_model (
    input wire pclk,
    input wire level_req,
    output reg timer_in
);
    reg [2:0] hold;
    initial begin
        timer_in = 1'b0;
        hold = 3'h0;
    end
    // keep each level at least five clocks
    always @(posedge pclk) begin
        if (hold < 3'h4)
            hold <= hold + 3'h1;
        else if (level_req !== timer_in) begin
            timer_in <= level_req;
            hold <= 3'h0;
        end
    end
endmodule // rtp_pin_model

/* test/test_rtp_timer.sv */
/* self-checking bench for rtp_timer over apb.
   assumes the pin model drives the timer input. */
`timescale 1ns/100ps
module test_rtp_timer;
    reg         pclk, presetn, psel, penable, pwrite, pin_req, err;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd, r2;
    wire [31:0] prdata;
    wire        pready, pslverr, timer_in, pwm_out, pwm_out_n, pwm_oe_n;
    wire        reload_pulse, capture_pulse, irq;
    integer     bad_count, check_count, i, hi, lo, n;

    rtp_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_in(timer_in), .pwm_out(pwm_out), .pwm_out_n(pwm_out_n),
        .pwm_oe_n(pwm_oe_n), .reload_pulse(reload_pulse),
        .capture_pulse(capture_pulse), .irq(irq));
    rtp_pin_model u_pin (.pclk(pclk), .level_req(pin_req),
        .timer_in(timer_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task wrap_up;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                $display("mismatch %s expected %h seen %h", nm, e, g);
                bad_count = bad_count + 1;
            end
        end
    endtask

    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            // let the release of the last transfer reach an edge first
            if (psel) begin
                @(posedge pclk);
            end
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            if (pready !== 1'b1) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdchk(input string nm, input [7:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            chk(nm, e, rd);
        end
    endtask

    // n returns the clocks waited for the pulse
    task wait_ev(input cap, input integer lim);
        begin
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while ((cap ? capture_pulse : reload_pulse) !== 1'b1
                       && n < lim);
            if ((cap ? capture_pulse : reload_pulse) !== 1'b1) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
        end
    endtask

    initial begin
        bad_count = 0;
        check_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, pin_req, paddr, pwdata} = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("ctl", 8'h00, 32'h0);
        rdchk("count", 8'h04, 32'h1);
        rdchk("reload", 8'h08, 32'hffff);
        rdchk("pwm", 8'h0c, 32'h0);
        rdchk("ctl2", 8'h10, 32'h0);
        rdchk("stat", 8'h14, 32'h0);
        rdchk("mask", 8'h18, 32'h0);
        rdchk("unmapped", 8'h1c, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        for (i = 0; i < 2; i = i + 1) begin
            xfer(1'b1, 8'h00, 32'h04);
            xfer(1'b1, 8'h04, 32'h1);
            xfer(1'b1, 8'h08, 32'h8);
            xfer(1'b1, 8'h0c, 32'h3);
            xfer(1'b1, 8'h10, i * 3);
            xfer(1'b1, 8'h00, 32'h05 | (i << 5));
            wait_ev(1'b0, 100);
            wait_ev(1'b0, 40);
            chk("period", 32'd16, n);
            hi = 0;
            lo = 0;
            repeat (16) begin
                @(posedge pclk);
                hi = hi + pwm_out;
                lo = lo + pwm_out_n;
            end
            chk("high", i ? 3 : 10, hi);
            chk("low", i ? 7 : 6, lo);
            chk("oe_n", 32'h0, {31'h0, pwm_oe_n});
        end
        rdchk("stat", 8'h14, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, 8'h18, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1'b1, 8'h00, 32'h04);
        xfer(1'b1, 8'h14, 32'h3);
        rdchk("stat", 8'h14, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b0, 8'h04, 32'h0);
        r2 = rd;
        repeat (40) @(posedge pclk);
        rdchk("frozen", 8'h04, r2);
        xfer(1'b1, 8'h00, 32'h22);
        xfer(1'b1, 8'h04, 32'h1);
        xfer(1'b1, 8'h08, 32'hffff);
        xfer(1'b1, 8'h0c, 32'h0);
        xfer(1'b1, 8'h00, 32'h23);
        pin_req <= 1'b1;
        wait_ev(1'b1, 40);
        rdchk("flag", 8'h10, 32'h103);
        rdchk("stat", 8'h14, 32'h2);
        xfer(1'b0, 8'h0c, 32'h0);
        r2 = rd;
        chk("captured", 32'h1, {31'h0, r2 != 0});
        pin_req <= 1'b0;
        repeat (30) @(posedge pclk);
        rdchk("no fall", 8'h0c, r2);
        chk("cap oe", 32'h1, {31'h0, pwm_oe_n});
        xfer(1'b1, 8'h04, 32'h1);
        xfer(1'b1, 8'h08, 32'h10);
        wait_ev(1'b0, 100);
        rdchk("flag clr", 8'h10, 32'h3);
        xfer(1'b1, 8'h04, 32'hc);
        wait_ev(1'b0, 20);
        chk("first period", 32'd6, n);
        wrap_up;
    end
endmodule // test_rtp_timer
